// *** lmac_pkg.sv ***
// constants, register map and types for the legacy modem address compat block
package lmac_pkg;

   // ----------------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] LMAC_OFS_CTRL     = 8'h00;
   localparam logic [7:0] LMAC_OFS_MODE     = 8'h04;
   localparam logic [7:0] LMAC_OFS_TX_ADDR  = 8'h08;
   localparam logic [7:0] LMAC_OFS_RX_ADDR  = 8'h0c;
   localparam logic [7:0] LMAC_OFS_TX_DELAY = 8'h10;
   localparam logic [7:0] LMAC_OFS_EOM_GAP  = 8'h14;
   localparam logic [7:0] LMAC_OFS_BYTE_CYC = 8'h18;
   localparam logic [7:0] LMAC_OFS_REPEAT   = 8'h1c;
   localparam logic [7:0] LMAC_OFS_STATUS   = 8'h20;
   localparam logic [7:0] LMAC_OFS_RX_DROP  = 8'h24;

   // ----------------------------------------------------------------
   // control register fields
   // ----------------------------------------------------------------
   localparam int LMAC_CTRL_TX_ADDR_EN = 0;
   localparam int LMAC_CTRL_RX_ADDR_EN = 1;
   localparam int LMAC_CTRL_FEC        = 2;
   localparam int LMAC_CTRL_ERR_CHECK  = 3;
   localparam int LMAC_CTRL_CRC16      = 4;
   localparam int LMAC_CTRL_RX_PRIO    = 5;

   // ----------------------------------------------------------------
   // status register fields
   // ----------------------------------------------------------------
   localparam int LMAC_ST_FEC_ACTIVE  = 0;
   localparam int LMAC_ST_FEC_SUSP    = 1;
   localparam int LMAC_ST_TX_ADDR_EFF = 2;
   localparam int LMAC_ST_RX_ADDR_EFF = 3;
   localparam int LMAC_ST_DELAY_SHORT = 4;
   localparam int LMAC_ST_TX_BUSY     = 5;
   localparam int LMAC_ST_INTEROP_OK  = 6;

   // ----------------------------------------------------------------
   // reset values and fixed codes
   // ----------------------------------------------------------------
   localparam logic [15:0] LMAC_TX_ADDR_RST  = 16'h00ff;
   localparam logic [15:0] LMAC_RX_ADDR_RST  = 16'h0000;
   localparam logic [7:0]  LMAC_BROADCAST    = 8'hff;
   localparam logic [5:0]  LMAC_MODE_RST     = 6'h00;
   localparam logic [5:0]  LMAC_OPT_NATIVE4  = 6'h00;
   localparam logic [5:0]  LMAC_OPT_LEGACY   = 6'h06;
   localparam logic [5:0]  LMAC_OPT_8FSK1    = 6'h14;
   localparam logic [5:0]  LMAC_OPT_8FSK2    = 6'h15;
   localparam logic [5:0]  LMAC_OPT_16FSK    = 6'h16;
   localparam logic [5:0]  LMAC_OPT_NO_ADDR  = 6'h03;
   localparam logic [5:0]  LMAC_CTRL_RST     = 6'h00;
   localparam logic [15:0] LMAC_TX_DELAY_RST = 16'h0000;
   localparam logic [15:0] LMAC_DELAY_ACK_MS = 16'h0032;
   localparam logic [15:0] LMAC_DELAY_LAT_MS = 16'h0022;
   localparam logic [7:0]  LMAC_EOM_GAP_RST  = 8'h03;
   localparam logic [23:0] LMAC_BYTE_CYC_RST = 24'h032dcd;
   localparam logic [7:0]  LMAC_REP_ON_CHAR  = 8'h52;
   localparam logic [7:0]  LMAC_REP_OFF_CHAR = 8'h4f;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int unsigned LMAC_CLK_PERIOD_NS = 5;
   localparam int unsigned LMAC_NS_PER_MS     = 1000000;
   localparam int unsigned LMAC_CYCLES_PER_MS =
      LMAC_NS_PER_MS / LMAC_CLK_PERIOD_NS;

   typedef enum logic [3:0] {
      LMAC_TX_IDLE   = 4'b0001,
      LMAC_TX_DELAY  = 4'b0010,
      LMAC_TX_HEADER = 4'b0100,
      LMAC_TX_DATA   = 4'b1000
   } lmac_tx_state_type;

endpackage

// *** lmac_delay_timer.sv ***
// millisecond delay timer: pulses done after a programmed count of ms
`timescale 1ns/10ps
module lmac_delay_timer
   import lmac_pkg::*;
#(
   parameter int unsigned CYCLES_PER_MS = LMAC_CYCLES_PER_MS
)
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        start,
   input  wire logic [15:0] delay_ms,
   output logic             done
);
   logic [31:0] prescale;
   logic [15:0] ms_left;
   logic        running;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prescale <= 32'h0;
         ms_left  <= 16'h0;
         running  <= 1'b0;
         done     <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            prescale <= 32'h0;
            ms_left  <= delay_ms;
            running  <= 1'b1;
         end else if (running) begin
            if (ms_left == 16'h0) begin
               running <= 1'b0;
               done    <= 1'b1;
            end else if (prescale == 32'(CYCLES_PER_MS - 1)) begin
               prescale <= 32'h0;
               ms_left  <= ms_left - 16'h1;
            end else begin
               prescale <= prescale + 32'h1;
            end
         end
      end
   end
endmodule // lmac_delay_timer

// *** lmac_gap_timer.sv ***
// idle gap detector counted in serial byte intervals
`timescale 1ns/10ps
module lmac_gap_timer (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        kick,
   input  wire logic [23:0] byte_cycles,
   input  wire logic [7:0]  gap_bytes,
   output logic             gap_seen
);
   logic [23:0] cyc;
   logic [7:0]  bytes;
   logic        armed;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cyc      <= 24'h0;
         bytes    <= 8'h0;
         armed    <= 1'b0;
         gap_seen <= 1'b0;
      end else begin
         gap_seen <= 1'b0;
         if (kick) begin
            cyc   <= 24'h0;
            bytes <= 8'h0;
            armed <= 1'b1;
         end else if (armed) begin
            if (bytes >= gap_bytes) begin
               armed    <= 1'b0;
               gap_seen <= 1'b1;
            end else if (cyc + 24'h1 >= byte_cycles) begin
               cyc   <= 24'h0;
               bytes <= bytes + 8'h1;
            end else begin
               cyc <= cyc + 24'h1;
            end
         end
      end
   end
endmodule // lmac_gap_timer

// *** lmac_top.sv ***
// legacy modem address compat block: ahb registers, tx framer, rx filter
`timescale 1ns/10ps

module lmac_top
   import lmac_pkg::*;
#(
   parameter int unsigned CYCLES_PER_MS = LMAC_CYCLES_PER_MS
)
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [7:0]  host_tx_data,
   input  wire logic        host_tx_valid,
   output logic             host_tx_ready,
   output logic [7:0]       air_tx_data,
   output logic             air_tx_valid,
   output logic             air_tx_last,
   input  wire logic [7:0]  air_rx_data,
   input  wire logic        air_rx_valid,
   input  wire logic        air_rx_first,
   output logic [7:0]       host_rx_data,
   output logic             host_rx_valid,
   output logic             fec_native_active,
   output logic             error_check_active,
   output logic             crc16_check_active,
   output logic             repeater_on,
   output logic             carrier_sense_on
);
   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [5:0]        ctrl;
   logic [5:0]        compat_mode;
   logic              fec_saved;
   logic              fec_suspended;
   logic [15:0]       primary_tx_address;
   logic [15:0]       primary_rx_address;
   logic [15:0]       tx_delay_ms;
   logic [7:0]        end_of_message_timeout;
   logic [23:0]       byte_cycles;
   logic [15:0]       rx_drop_count;
   lmac_tx_state_type tx_state;
   logic              rx_pass;

   // ----------------------------------------------------------------
   // ahb-lite slave, zero wait states
   // ----------------------------------------------------------------
   logic       ap_valid;
   logic       ap_write;
   logic [7:0] ap_addr;
   logic       take;
   logic       wr;
   logic [31:0] rd_value;

   assign take = hsel & hready & htrans[1];
   assign wr   = ap_valid & ap_write;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_valid  <= 1'b0;
         ap_write  <= 1'b0;
         ap_addr   <= 8'h0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         ap_valid  <= take;
         ap_write  <= hwrite;
         ap_addr   <= haddr[7:0];
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // derived mode state
   // ----------------------------------------------------------------
   logic in_no_addr;
   logic native_mode;
   logic tx_addr_eff;
   logic rx_addr_eff;
   logic delay_short;
   logic interop_ok;

   assign in_no_addr  = (compat_mode == LMAC_OPT_NO_ADDR);
   assign native_mode = (compat_mode == LMAC_OPT_NATIVE4)
                      | (compat_mode == LMAC_OPT_LEGACY)
                      | (compat_mode == LMAC_OPT_8FSK1)
                      | (compat_mode == LMAC_OPT_8FSK2)
                      | (compat_mode == LMAC_OPT_16FSK);
   // addressing is meaningless in option 3, so it is forced off there
   assign tx_addr_eff = ctrl[LMAC_CTRL_TX_ADDR_EN] & ~in_no_addr;
   assign rx_addr_eff = ctrl[LMAC_CTRL_RX_ADDR_EN] & ~in_no_addr;
   // flag for software: acked partner systems want a longer delay
   assign delay_short = tx_addr_eff
                      & (tx_delay_ms < LMAC_DELAY_ACK_MS);
   assign interop_ok  = ~error_check_active & ~crc16_check_active;

   always_comb begin
      rd_value = 32'h0;
      unique case (haddr[7:0])
         LMAC_OFS_CTRL:     rd_value = {26'h0, ctrl};
         LMAC_OFS_MODE:     rd_value = {26'h0, compat_mode};
         LMAC_OFS_TX_ADDR:  rd_value = {16'h0, primary_tx_address};
         LMAC_OFS_RX_ADDR:  rd_value = {16'h0, primary_rx_address};
         LMAC_OFS_TX_DELAY: rd_value = {16'h0, tx_delay_ms};
         LMAC_OFS_EOM_GAP:  rd_value = {24'h0, end_of_message_timeout};
         LMAC_OFS_BYTE_CYC: rd_value = {8'h0, byte_cycles};
         LMAC_OFS_REPEAT:   rd_value = {31'h0, repeater_on};
         LMAC_OFS_STATUS: begin
            rd_value[LMAC_ST_FEC_ACTIVE]  = fec_native_active;
            rd_value[LMAC_ST_FEC_SUSP]    = fec_suspended;
            rd_value[LMAC_ST_TX_ADDR_EFF] = tx_addr_eff;
            rd_value[LMAC_ST_RX_ADDR_EFF] = rx_addr_eff;
            rd_value[LMAC_ST_DELAY_SHORT] = delay_short;
            rd_value[LMAC_ST_TX_BUSY]     = (tx_state != LMAC_TX_IDLE);
            rd_value[LMAC_ST_INTEROP_OK]  = interop_ok;
         end
         LMAC_OFS_RX_DROP:  rd_value = {16'h0, rx_drop_count};
         default:           rd_value = 32'h0;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0;
      end else if (take & ~hwrite) begin
         hrdata <= rd_value;
      end else begin
         hrdata <= 32'h0;
      end
   end

   // ----------------------------------------------------------------
   // control and mode select, with fec suspend around option 3
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl          <= LMAC_CTRL_RST;
         compat_mode   <= LMAC_MODE_RST;
         fec_saved     <= 1'b0;
         fec_suspended <= 1'b0;
      end else if (wr && ap_addr == LMAC_OFS_CTRL) begin
         ctrl <= hwdata[5:0];
         // fec writes while suspended land in the saved copy
         if (fec_suspended) begin
            ctrl[LMAC_CTRL_FEC] <= 1'b0;
            fec_saved           <= hwdata[LMAC_CTRL_FEC];
         end
      end else if (wr && ap_addr == LMAC_OFS_MODE) begin
         compat_mode <= hwdata[5:0];
         if (hwdata[5:0] == LMAC_OPT_NO_ADDR && !in_no_addr) begin
            fec_saved           <= ctrl[LMAC_CTRL_FEC];
            fec_suspended       <= ctrl[LMAC_CTRL_FEC];
            ctrl[LMAC_CTRL_FEC] <= 1'b0;
         end else if (hwdata[5:0] != LMAC_OPT_NO_ADDR && fec_suspended) begin
            ctrl[LMAC_CTRL_FEC] <= fec_saved;
            fec_suspended       <= 1'b0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         primary_tx_address     <= LMAC_TX_ADDR_RST;
         primary_rx_address     <= LMAC_RX_ADDR_RST;
         tx_delay_ms            <= LMAC_TX_DELAY_RST;
         end_of_message_timeout <= LMAC_EOM_GAP_RST;
         byte_cycles            <= LMAC_BYTE_CYC_RST;
      end else if (wr) begin
         if (ap_addr == LMAC_OFS_TX_ADDR)
            primary_tx_address <= hwdata[15:0];
         if (ap_addr == LMAC_OFS_RX_ADDR)
            primary_rx_address <= hwdata[15:0];
         if (ap_addr == LMAC_OFS_TX_DELAY)
            tx_delay_ms <= hwdata[15:0];
         if (ap_addr == LMAC_OFS_EOM_GAP)
            end_of_message_timeout <= hwdata[7:0];
         if (ap_addr == LMAC_OFS_BYTE_CYC)
            byte_cycles <= hwdata[23:0];
      end
   end

   // repeater command takes a character; anything else is ignored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         repeater_on <= 1'b0;
      end else if (wr && ap_addr == LMAC_OFS_REPEAT) begin
         if (hwdata[7:0] == LMAC_REP_ON_CHAR)
            repeater_on <= 1'b1;
         else if (hwdata[7:0] == LMAC_REP_OFF_CHAR)
            repeater_on <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // outputs to the modem core; fec and checks are mode-qualified, carrier sense is not
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fec_native_active  <= 1'b0;
         error_check_active <= 1'b0;
         crc16_check_active <= 1'b0;
         carrier_sense_on   <= 1'b0;
      end else begin
         fec_native_active  <= ctrl[LMAC_CTRL_FEC]
                             & (compat_mode == LMAC_OPT_NATIVE4);
         error_check_active <= ctrl[LMAC_CTRL_ERR_CHECK]
                             & native_mode;
         crc16_check_active <= ctrl[LMAC_CTRL_CRC16]
                             & native_mode;
         carrier_sense_on   <= ctrl[LMAC_CTRL_RX_PRIO];
      end
   end

   // ----------------------------------------------------------------
   // transmit framer
   // ----------------------------------------------------------------
   logic delay_done;
   logic gap_seen;
   logic tx_accept;
   logic gap_kick;

   assign tx_accept = host_tx_valid & host_tx_ready;
   assign gap_kick  = tx_accept | (tx_state != LMAC_TX_DATA
                                   && (delay_done
                                       || tx_state == LMAC_TX_HEADER));

   lmac_delay_timer #(
      .CYCLES_PER_MS (CYCLES_PER_MS)
   ) u_delay (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .start    (tx_state == LMAC_TX_IDLE && host_tx_valid),
      .delay_ms (tx_delay_ms),
      .done     (delay_done)
   );

   lmac_gap_timer u_gap (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .kick        (gap_kick),
      .byte_cycles (byte_cycles),
      .gap_bytes   (end_of_message_timeout),
      .gap_seen    (gap_seen)
   );

   // single shot: no ack wait, no retry once the gap ends the message
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_state      <= LMAC_TX_IDLE;
         host_tx_ready <= 1'b0;
         air_tx_data   <= 8'h0;
         air_tx_valid  <= 1'b0;
         air_tx_last   <= 1'b0;
      end else begin
         air_tx_valid <= 1'b0;
         air_tx_last  <= 1'b0;
         unique case (tx_state)
            LMAC_TX_IDLE: begin
               if (host_tx_valid)
                  tx_state <= LMAC_TX_DELAY;
            end
            LMAC_TX_DELAY: begin
               if (delay_done) begin
                  if (tx_addr_eff) begin
                     tx_state <= LMAC_TX_HEADER;
                  end else begin
                     tx_state      <= LMAC_TX_DATA;
                     host_tx_ready <= 1'b1;
                  end
               end
            end
            LMAC_TX_HEADER: begin
               air_tx_data   <= primary_tx_address[7:0];
               air_tx_valid  <= 1'b1;
               tx_state      <= LMAC_TX_DATA;
               host_tx_ready <= 1'b1;
            end
            LMAC_TX_DATA: begin
               if (tx_accept) begin
                  air_tx_data  <= host_tx_data;
                  air_tx_valid <= 1'b1;
               end else if (gap_seen) begin
                  air_tx_last   <= 1'b1;
                  host_tx_ready <= 1'b0;
                  tx_state      <= LMAC_TX_IDLE;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // receive address filter; the decision is made on the first byte
   // so no message buffer is needed
   // ----------------------------------------------------------------
   logic dest_match;

   assign dest_match = (air_rx_data == primary_rx_address[7:0])
                     | (air_rx_data == LMAC_BROADCAST);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_pass       <= 1'b0;
         host_rx_data  <= 8'h0;
         host_rx_valid <= 1'b0;
         rx_drop_count <= 16'h0;
      end else begin
         host_rx_valid <= 1'b0;
         if (air_rx_valid && air_rx_first && rx_addr_eff) begin
            rx_pass <= dest_match;
            if (!dest_match)
               rx_drop_count <= rx_drop_count + 16'h1;
         end else if (air_rx_valid) begin
            if (air_rx_first)
               rx_pass <= 1'b1;
            if (air_rx_first || rx_pass) begin
               host_rx_data  <= air_rx_data;
               host_rx_valid <= 1'b1;
            end
         end
      end
   end
endmodule // lmac_top

// *** lmac_sva.sv ***
// port timing checker for the address compat block
`timescale 1ns/10ps
module lmac_sva #(
   parameter int unsigned CYCLES_PER_MS = 4
)
(
   input wire logic       hclk,
   input wire logic       hresetn,
   input wire logic       hreadyout,
   input wire logic       hresp,
   input wire logic [7:0] host_tx_data,
   input wire logic       host_tx_valid,
   input wire logic       host_tx_ready,
   input wire logic [7:0] air_tx_data,
   input wire logic       air_tx_valid,
   input wire logic       air_tx_last,
   input wire logic [7:0] air_rx_data,
   input wire logic       air_rx_valid,
   input wire logic [7:0] host_rx_data,
   input wire logic       host_rx_valid
);
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_okay; hresp == 1'b0; endproperty
   a_okay: assert property (p_okay) else $error("bus response not okay");
   property p_rdy; hreadyout == 1'b1; endproperty
   a_rdy: assert property (p_rdy) else $error("wait state inserted");
   property p_rx_src; host_rx_valid |-> $past(air_rx_valid); endproperty
   a_rx_src: assert property (p_rx_src) else $error("rx byte");
   property p_rx_dat;
      host_rx_valid |-> host_rx_data == $past(air_rx_data);
   endproperty
   a_rx_dat: assert property (p_rx_dat) else $error("rx data");
   property p_tx_fwd;
      host_tx_valid && host_tx_ready |=>
         air_tx_valid && air_tx_data == $past(host_tx_data);
   endproperty
   a_tx_fwd: assert property (p_tx_fwd) else $error("tx byte");
   property p_last; air_tx_last |=> !air_tx_last; endproperty
   a_last: assert property (p_last) else $error("end pulse");
   property p_once; air_tx_last |-> !air_tx_valid [*3]; endproperty
   a_once: assert property (p_once) else $error("tx after end");
   property p_stop; air_tx_last |=> !host_tx_ready; endproperty
   a_stop: assert property (p_stop) else $error("ready held");
endmodule // lmac_sva

bind lmac_top lmac_sva #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_sva (
   .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
   .host_tx_data(host_tx_data), .host_tx_valid(host_tx_valid),
   .host_tx_ready(host_tx_ready), .air_tx_data(air_tx_data),
   .air_tx_valid(air_tx_valid), .air_tx_last(air_tx_last),
   .air_rx_data(air_rx_data), .air_rx_valid(air_rx_valid),
   .host_rx_data(host_rx_data), .host_rx_valid(host_rx_valid));

// *** lmac_far_radio.sv ***
// far radio model: sends frames on air rx, collects air tx bytes
`timescale 1ns/10ps
module lmac_far_radio #(
   parameter logic [7:0] LOCAL_ADDR    = 8'h00,
   parameter logic [7:0] SECURITY_CODE = 8'h00
)
(
   input  wire logic       hclk,
   input  wire logic [7:0] air_tx_data,
   input  wire logic       air_tx_valid,
   output logic [7:0]      air_rx_data = 8'h00,
   output logic            air_rx_valid = 1'b0,
   output logic            air_rx_first = 1'b0
);
   logic [7:0] got_q[$];
   int         taken = 0;
   // a frame is ours when its first byte is our address or broadcast
   always @(posedge hclk) begin
      if (air_tx_valid === 1'b1 && got_q.size() == 0 &&
          (air_tx_data == LOCAL_ADDR || air_tx_data == 8'hff)) begin
         taken++;
      end
      if (air_tx_valid === 1'b1) begin
         got_q.push_back(air_tx_data);
      end
   end
   task automatic send(input logic [7:0] dest, input logic [15:0] body);
      for (int i = 0; i < 3; i++) begin
         @(posedge hclk);
         air_rx_valid <= 1'b1;
         air_rx_first <= (i == 0);
         air_rx_data  <= i == 0 ? dest : i == 1 ? body[15:8] : body[7:0];
      end
      @(posedge hclk);
      air_rx_valid <= 1'b0;
      air_rx_first <= 1'b0;
      // released line flips, so a stale byte never looks valid
      air_rx_data  <= ~air_rx_data;
   endtask
endmodule // lmac_far_radio

// *** tb.sv ***
// self-checking bench for the address compat block
`timescale 1ns/10ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_total++; \
$display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
`define W(a, d) ahb(1'b1, a, d)
`define R(a) ahb(1'b0, a, 32'h0)
module tb
   import lmac_pkg::*;
;
   // ----------------------------------------------------------------
   // signals, design and far radio
   // ----------------------------------------------------------------
   localparam int unsigned CPM = 4;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
   logic [1:0]  htrans = 2'b00;
   logic [7:0]  host_tx_data = 8'h00, air_tx_data, air_rx_data;
   logic [7:0]  host_rx_data, rxq[$];
   logic        host_tx_valid = 1'b0, host_tx_ready, hreadyout, hresp;
   logic        air_tx_valid, air_tx_last, air_rx_valid, air_rx_first;
   logic        host_rx_valid, fec_on, err_on, crc_on, rep_on, cs_on;
   int          err_total = 0;
   int          checked = 0;
   wire logic   hready = hreadyout;
   lmac_top #(.CYCLES_PER_MS(CPM)) uut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .host_tx_data(host_tx_data),
      .host_tx_valid(host_tx_valid), .host_tx_ready(host_tx_ready),
      .air_tx_data(air_tx_data), .air_tx_valid(air_tx_valid),
      .air_tx_last(air_tx_last), .air_rx_data(air_rx_data),
      .air_rx_valid(air_rx_valid), .air_rx_first(air_rx_first),
      .host_rx_data(host_rx_data), .host_rx_valid(host_rx_valid),
      .fec_native_active(fec_on), .error_check_active(err_on),
      .crc16_check_active(crc_on), .repeater_on(rep_on),
      .carrier_sense_on(cs_on));
   lmac_far_radio u_far (.hclk(hclk), .air_tx_data(air_tx_data),
      .air_tx_valid(air_tx_valid), .air_rx_data(air_rx_data),
      .air_rx_valid(air_rx_valid), .air_rx_first(air_rx_first));
   always #2.5 hclk = ~hclk;
   always @(posedge hclk) begin
      if (host_rx_valid === 1'b1) begin
         rxq.push_back(host_rx_data);
      end
   end
   // ----------------------------------------------------------------
   // bus and stream tasks
   // ----------------------------------------------------------------
   task automatic end_of_test;
      $display("checked %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // 0 bus ready, 1 stream ready, 2 end of message; sampled on the falling edge, ends on the next rising edge
   task automatic wait_hi(input int w);
      int n;
      n = 0;
      do begin
         @(negedge hclk);
         q = hrdata;
         n++;
         if (n > 3000) begin
            err_total++;
            end_of_test();
         end
      end while ((w == 0 ? hreadyout : w == 1 ? host_tx_ready
                  : air_tx_last) !== 1'b1);
      @(posedge hclk);
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr  <= {24'h0, a};
      wait_hi(0);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_hi(0);
   endtask
   task automatic hsend2(input logic [15:0] b);
      u_far.got_q.delete();
      host_tx_valid <= 1'b1;
      host_tx_data  <= b[15:8];
      wait_hi(1);
      host_tx_data  <= b[7:0];
      wait_hi(1);
      host_tx_valid <= 1'b0;
      wait_hi(2);
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_tx;
      time t0;
      `R(LMAC_OFS_TX_ADDR);
      `CHK(q, 32'h000000ff)
      `R(LMAC_OFS_RX_ADDR);
      `CHK(q, 32'h0)
      `CHK(cs_on, 1'b0)
      `W(8'h40, 32'h5a);
      `R(8'h40);
      `CHK(q, 32'h0)
      `W(LMAC_OFS_BYTE_CYC, 32'h4);
      `W(LMAC_OFS_EOM_GAP, 32'h2);
      `W(LMAC_OFS_CTRL, 32'h1);
      hsend2(16'ha1a2);
      `CHK(u_far.got_q.size(), 3)
      `CHK(u_far.got_q[0], 8'hff)
      `CHK(u_far.got_q[2], 8'ha2)
      `CHK(u_far.taken, 1)
      `W(LMAC_OFS_TX_ADDR, 32'h5);
      `W(LMAC_OFS_TX_DELAY, 32'h22);
      t0 = $time;
      hsend2(16'hb1b2);
      `CHK(u_far.got_q[0], 8'h05)
      `CHK(u_far.taken, 1)
      `CHK($time - t0 > 34 * CPM * 5, 1'b1)
      $display("t_tx done");
   endtask
   task automatic t_rx;
      `W(LMAC_OFS_CTRL, 32'h2);
      `W(LMAC_OFS_RX_ADDR, 32'h12);
      rxq.delete();
      u_far.send(8'h12, 16'hb1b2);
      u_far.send(8'hff, 16'hc1c2);
      u_far.send(8'h34, 16'hd1d2);
      repeat (3) @(posedge hclk);
      `CHK(rxq.size(), 4)
      `CHK(rxq[0], 8'hb1)
      `CHK(rxq[2], 8'hc1)
      `R(LMAC_OFS_RX_DROP);
      `CHK(q, 32'h1)
      $display("t_rx done");
   endtask
   task automatic t_mode3;
      `W(LMAC_OFS_CTRL, 32'h7);
      `W(LMAC_OFS_MODE, 32'h3);
      `R(LMAC_OFS_STATUS);
      `CHK(q[3:1], 3'b001)
      `CHK(fec_on, 1'b0)
      rxq.delete();
      u_far.send(8'h55, 16'he1e2);
      repeat (3) @(posedge hclk);
      `CHK(rxq.size(), 3)
      `W(LMAC_OFS_MODE, 32'h0);
      `R(LMAC_OFS_CTRL);
      `CHK(q[2], 1'b1)
      `CHK(fec_on, 1'b1)
      `W(LMAC_OFS_CTRL, 32'h1c);
      // partner option 1: its own fec binding, checks forced off
      `W(LMAC_OFS_MODE, 32'h1);
      repeat (3) @(posedge hclk);
      `CHK(fec_on, 1'b0)
      `CHK({err_on, crc_on}, 2'b00)
      $display("t_mode3 done");
   endtask
   task automatic t_misc;
      logic [7:0] cmd[3] = '{8'h52, 8'h41, 8'h4f};
      logic       exp[3] = '{1'b1, 1'b1, 1'b0};
      for (int i = 0; i < 3; i++) begin
         `W(LMAC_OFS_REPEAT, {24'h0, cmd[i]});
         repeat (3) @(posedge hclk);
         `CHK(rep_on, exp[i])
      end
      `W(LMAC_OFS_CTRL, 32'h21);
      `W(LMAC_OFS_TX_DELAY, 32'h32);
      `R(LMAC_OFS_STATUS);
      `CHK(q[4], 1'b0)
      `CHK(cs_on, 1'b1)
      `W(LMAC_OFS_TX_DELAY, 32'h31);
      `R(LMAC_OFS_STATUS);
      `CHK(q[4], 1'b1)
      $display("t_misc done");
   endtask
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_tx();
      t_rx();
      t_mode3();
      t_misc();
      end_of_test();
   end
endmodule // tb
